// [rtl/seq_pkg.sv]
/*
  constants, field layouts and carrier types for the analyzer ram address sequencer.
  assumes one 200 mhz clock (ref_clk) and a synchronous active-high reset.
*/
// What this block does
// - ram address is box address plus byte
// - box counter steps on divider and step pulse
// - zero-phase sync loads 152, counts to 255
// - above 4hz synchronous carry bumps cycle counter
// - below 4hz asynchronous carry bumps cycle counter
// - async box counter lockstep, loadable via d0
// - async measurement starts anywhere, carries at box 255
// - d1 selects asynchronous measurement mode
// - phi prescaler by four drives down counter
// - one five-byte sequence per step pulse
// - idle with both carries held high
// - step loads prescaler 12, carry every fourth
// - down counter steps on prescaler carry
// - ram disabled while byte address changes
// - control bit 2 selects high/low band
// - high band ignores sync, counters always enabled
// - cycle register 256-n loaded at measurement start
// - box and cycle counters count only while priming is asserted
package seq_pkg;

  // register word indices on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CYCLE = 4'h1;
  localparam logic [3:0] ADDR_ASYNC_START = 4'h2;
  localparam logic [3:0] ADDR_SYNC_BOX = 4'h3;
  localparam logic [3:0] ADDR_ASYNC_BOX = 4'h4;
  localparam logic [3:0] ADDR_CYCLE_COUNT = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CYCLE_RESET = 8'h00;
  localparam logic [7:0] ASYNC_START_RESET = 8'h98;

  // box counter range: 104 boxes per analysis cycle
  localparam logic [7:0] BOX_BASE = 8'h98;
  localparam logic [7:0] BOX_TOP = 8'hff;
  localparam logic [7:0] CYCLE_TOP = 8'hff;

  // rate divider in half steps so that 1.5 is exact on average
  localparam logic [4:0] RATE_HALF_STEP = 5'h02;
  localparam logic [4:0] RATE_THR_15 = 5'h1e;
  localparam logic [4:0] RATE_THR_3 = 5'h06;
  localparam logic [4:0] RATE_THR_1P5 = 5'h03;
  localparam logic [1:0] RATE_SEL_15 = 2'h0;
  localparam logic [1:0] RATE_SEL_3 = 2'h1;

  // byte slot timing: prescaler 12..15, ten read/write slots
  localparam logic [3:0] PRESC_LOAD = 4'hc;
  localparam logic [3:0] PRESC_TOP = 4'hf;
  localparam logic [3:0] SLOT_LAST = 4'h9;

  // control register layout, top bit first
  typedef struct packed {
    logic [2:0] spare;
    logic [1:0] rate_sel;
    logic band_select;
    logic async_measure_select_bit;
    logic async_start_load_bit;
  } ctrl_s;

  // analyzer ram address: box above byte
  typedef struct packed {
    logic [7:0] box;
    logic [2:0] byte_sel;
  } ram_addr_s;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_e;

endpackage

// [rtl/byte_sequencer.sv]
/*
  byte address sequencer: prescaler and down counter walking the five bytes of a box.
  assumes the step input is a one-cycle pulse already in the ref_clk domain.
*/
`timescale 1ns/1ps
module byte_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic step,
  output logic [2:0] byte_sel,
  output logic ram_read,
  output logic ram_en,
  output logic idle
);
  import seq_pkg::*;

  seq_state_e state;
  logic [3:0] presc;
  logic [3:0] down;
  logic presc_carry;
  logic [3:0] slot;

  assign presc_carry = (presc == PRESC_TOP);
  assign slot = SLOT_LAST - down;

  // prescaler and down counter; a step restarts even a running sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= SEQ_IDLE;
      presc <= PRESC_TOP;
      down <= 4'h0;
    end else if (step) begin
      state <= SEQ_RUN;
      presc <= PRESC_LOAD;
      down <= SLOT_LAST;
    end else begin
      case (state)
        SEQ_RUN: begin
          if (presc_carry) begin
            if (down == 4'h0) begin
              state <= SEQ_IDLE;
            end else begin
              down <= down - 4'h1;
              presc <= PRESC_LOAD;
            end
          end else begin
            presc <= presc + 4'h1;
          end
        end
        default: begin
          presc <= PRESC_TOP; // parked with carry high
        end
      endcase
    end
  end

  // registered outputs; even slots read, odd slots write back
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_sel <= 3'h0;
      ram_read <= 1'b1;
      ram_en <= 1'b0;
      idle <= 1'b1;
    end else begin
      byte_sel <= slot[3:1];
      ram_read <= ~slot[0];
      ram_en <= (state == SEQ_RUN) && (presc != PRESC_LOAD);
      idle <= (state == SEQ_IDLE);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence slot_start;
    (state == SEQ_RUN) && (presc == PRESC_LOAD) && !step;
  endsequence

  slot_len_a: assert property ((slot_start ##1 (!step) [*2]) |=> presc_carry)
    else $error("byte slot is not four clocks long");
  idle_carry_a: assert property ((state == SEQ_IDLE) |-> (presc_carry && down == 4'h0))
    else $error("idle sequencer without both carries high");
  ram_off_a: assert property (ram_en |-> ($past(presc) != PRESC_LOAD))
    else $error("ram enabled during byte address change");
  seq_end_a: assert property ((state == SEQ_RUN && down == 4'h0 && presc_carry && !step)
      |=> (state == SEQ_IDLE) ##1 (idle && !ram_en))
    else $error("sequence did not halt after last slot");
endmodule

// [rtl/analyzer_ram_address_sequencer.sv]
/*
  analyzer ram address sequencer: synchronous and asynchronous box counters, rate divider,
  cycle counter, control registers and the byte sequencer.
  assumes step and zero-phase pins are asynchronous; priming comes from same-clock logic.
*/
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module analyzer_ram_address_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic analysis_step_pulse,
  input wire logic zero_phase_sync,
  input wire logic priming_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output seq_pkg::ram_addr_s ram_addr,
  output logic ram_read,
  output logic ram_en,
  output logic cycle_done
);
  import seq_pkg::*;

  ctrl_s ctrl;
  logic [7:0] cycle_reg;
  logic [7:0] async_start;
  logic [7:0] sync_box;
  logic [7:0] async_box;
  logic [7:0] cycle_count;
  logic [4:0] rate_acc;
  logic [2:0] step_sync;
  logic [2:0] zero_sync;
  logic prime_d;
  logic sync_carry;
  logic async_carry;
  logic byte_idle;
  logic [2:0] byte_sel;
  logic seq_read;
  logic seq_en;

  logic step_edge;
  logic zero_edge;
  logic zero_load;
  logic async_load;
  logic prime_rise;
  logic rate_fire;
  logic advance;
  logic cycle_tick;
  logic [4:0] rate_sum;
  logic [4:0] rate_thr;

  // two flops before any logic, third flop only for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      step_sync <= 3'h0;
      zero_sync <= 3'h0;
    end else begin
      step_sync <= {step_sync[1:0], analysis_step_pulse};
      zero_sync <= {zero_sync[1:0], zero_phase_sync};
    end
  end

  assign step_edge = step_sync[1] && !step_sync[2];
  assign zero_edge = zero_sync[1] && !zero_sync[2];
  // high band: sync pulse is unrelated to the 393 hz cycle and would reset boxes at random
  assign zero_load = zero_edge && !ctrl.band_select;
  assign async_load = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[0];
  assign prime_rise = priming_enable && !prime_d;

  // rate divider threshold in half steps (15, 3 or 1.5)
  always_comb begin
    case (ctrl.rate_sel)
      RATE_SEL_15: rate_thr = RATE_THR_15;
      RATE_SEL_3: rate_thr = RATE_THR_3;
      default: rate_thr = RATE_THR_1P5;
    endcase
  end

  assign rate_sum = rate_acc + RATE_HALF_STEP;
  assign rate_fire = (rate_sum >= rate_thr);
  // high band keeps the counters enabled on every step
  assign advance = step_edge && priming_enable
      && (ctrl.band_select || rate_fire);
  // d1 picks which carry paces the measurement cycles
  assign cycle_tick = priming_enable
      && (ctrl.async_measure_select_bit ? async_carry : sync_carry);

  // rate divider counts step pulses in half units
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_acc <= 5'h00;
    end else if (step_edge && !ctrl.band_select) begin
      rate_acc <= rate_fire ? (rate_sum - rate_thr) : rate_sum;
    end
  end

  // synchronous box counter, phase-aligned by the zero-phase pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_box <= BOX_BASE;
      sync_carry <= 1'b0;
    end else begin
      sync_carry <= 1'b0;
      if (zero_load) begin
        sync_box <= BOX_BASE;
      end else if (advance) begin
        if (sync_box == BOX_TOP) begin
          sync_box <= BOX_BASE;
          sync_carry <= 1'b1;
        end else begin
          sync_box <= sync_box + 8'h01;
        end
      end
    end
  end

  // asynchronous box counter, starts anywhere; a cycle ends at the wrap from 255 to 152
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      async_box <= BOX_BASE;
      async_carry <= 1'b0;
    end else begin
      async_carry <= 1'b0;
      if (async_load) begin
        async_box <= async_start;
      end else if (advance) begin
        if (async_box == BOX_TOP) begin
          async_box <= BOX_BASE;
          async_carry <= 1'b1;
        end else begin
          async_box <= async_box + 8'h01;
        end
      end
    end
  end

  // cycle counter counts up from 256-n; overflow marks n cycles done
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prime_d <= 1'b0;
      cycle_count <= CYCLE_TOP;
      cycle_done <= 1'b0;
    end else begin
      prime_d <= priming_enable;
      cycle_done <= 1'b0;
      if (prime_rise) begin
        cycle_count <= cycle_reg;
      end else if (cycle_tick) begin
        if (cycle_count == CYCLE_TOP) begin
          cycle_count <= cycle_reg;
          cycle_done <= 1'b1;
        end else begin
          cycle_count <= cycle_count + 8'h01;
        end
      end
    end
  end

  // register writes; d0 is a load action, not stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      cycle_reg <= CYCLE_RESET;
      async_start <= ASYNC_START_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          ctrl <= reg_wdata;
          ctrl.async_start_load_bit <= 1'b0;
        end
        ADDR_CYCLE: cycle_reg <= reg_wdata;
        ADDR_ASYNC_START: async_start <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= ctrl;
        ADDR_CYCLE: reg_rdata <= cycle_reg;
        ADDR_ASYNC_START: reg_rdata <= async_start;
        ADDR_SYNC_BOX: reg_rdata <= sync_box;
        ADDR_ASYNC_BOX: reg_rdata <= async_box;
        ADDR_CYCLE_COUNT: reg_rdata <= cycle_count;
        ADDR_STATUS: reg_rdata <= {6'h00, priming_enable, byte_idle};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // one byte sequence per step pulse, whatever the rate divider says
  byte_sequencer u_bytes (
    .ref_clk(ref_clk),
    .rst(rst),
    .step(step_edge),
    .byte_sel(byte_sel),
    .ram_read(seq_read),
    .ram_en(seq_en),
    .idle(byte_idle)
  );

  // ram address: zero-phase box above byte; costs one cycle so all ram pins align
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_addr <= '0;
      ram_read <= 1'b1;
      ram_en <= 1'b0;
    end else begin
      ram_addr <= {sync_box, byte_sel};
      ram_read <= seq_read;
      ram_en <= seq_en;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence box_wrap;
    advance && !zero_load && (sync_box == BOX_TOP);
  endsequence

  sync_load_a: assert property (zero_load |=> (sync_box == BOX_BASE))
    else $error("zero-phase pulse did not load base count");
  box_wrap_a: assert property (box_wrap |=> (sync_box == BOX_BASE) && sync_carry)
    else $error("box counter did not carry and wrap at top");
  hf_ignore_a: assert property ((ctrl.band_select && zero_edge && !advance)
      |=> $stable(sync_box))
    else $error("high band reacted to zero-phase pulse");
  lockstep_a: assert property ((advance && !async_load && async_box != BOX_TOP)
      |=> (async_box == $past(async_box) + 8'h01))
    else $error("async box counter out of lockstep");
  prime_hold_a: assert property ((!priming_enable && !zero_load) |=> $stable(sync_box))
    else $error("box counter moved without priming");
  cycle_load_a: assert property (prime_rise |=> (cycle_count == $past(cycle_reg)))
    else $error("cycle counter not loaded at measurement start");
  sync_src_a: assert property ((sync_carry && priming_enable && !prime_rise
      && !ctrl.async_measure_select_bit && cycle_count != CYCLE_TOP)
      |=> (cycle_count == $past(cycle_count) + 8'h01))
    else $error("synchronous carry did not count a cycle");
  async_src_a: assert property ((ctrl.async_measure_select_bit && !async_carry && !prime_rise)
      |=> $stable(cycle_count))
    else $error("cycle counter moved without async carry");
  addr_pair_a: assert property (ram_en |-> (ram_addr.box == $past(sync_box)))
    else $error("ram box address not from box counter");
endmodule

// [test/synth_pulse_model.sv]
/*
  synthesizer timing pulse model driving the step and zero-phase pins.
  assumes the bench calls its tasks; both pins rest low between pulses.
*/
`timescale 1ns/1ps
module synth_pulse_model (
  input wire logic ref_clk,
  output logic analysis_step_pulse,
  output logic zero_phase_sync
);
  // pins rest low until a task pulses them
  initial begin
    analysis_step_pulse = 1'b0;
    zero_phase_sync = 1'b0;
  end

  // steady step train; gap picks fast or slow pacing
  task automatic steps(input int n, input int gap);
    repeat (n) begin
      @(posedge ref_clk);
      analysis_step_pulse <= 1'b1;
      repeat (2) @(posedge ref_clk);
      analysis_step_pulse <= 1'b0;
      repeat (gap) @(posedge ref_clk);
    end
  endtask

  // one zero-phase pulse, long enough for the pin synchroniser
  task automatic zero();
    @(posedge ref_clk);
    zero_phase_sync <= 1'b1;
    repeat (2) @(posedge ref_clk);
    zero_phase_sync <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// [test/test_analyzer_ram_address_sequencer.sv]
/*
  self-checking bench for the analyzer ram address sequencer.
  assumes the pulse model drives the step and zero-phase pins.
*/
`timescale 1ns/1ps
module test_analyzer_ram_address_sequencer;
  import seq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic priming_enable = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  ram_addr_s ram_addr;
  logic ram_read, ram_en, cycle_done, step_pin, zero_pin;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 77787;
  int run = 0;
  logic watch = 1'b0;
  logic rd_d = 1'b0;
  logic en_d = 1'b0;
  logic [11:0] last = 12'h000;
  logic [7:0] rd_q[$];
  logic [11:0] slot_q[$];
  logic [7:0] done_q[$];
  logic [7:0] s;

  always #2.5 ref_clk = ~ref_clk;

  synth_pulse_model i_synth_pulse_model (
    .ref_clk(ref_clk),
    .analysis_step_pulse(step_pin),
    .zero_phase_sync(zero_pin)
  );

  analyzer_ram_address_sequencer i_analyzer_ram_address_sequencer (
    .ref_clk(ref_clk), .rst(rst), .analysis_step_pulse(step_pin),
    .zero_phase_sync(zero_pin), .priming_enable(priming_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_addr(ram_addr),
    .ram_read(ram_read), .ram_en(ram_en), .cycle_done(cycle_done)
  );

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  // reset also drops priming so the next rise reloads the cycle count
  task automatic rst_dut();
    @(posedge ref_clk);
    rst <= 1'b1;
    priming_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic push_slots(input logic [7:0] box);
    for (int i = 0; i < 10; i++) begin
      slot_q.push_back({box, 3'(i / 2), ~i[0]});
    end
  endtask

  // result watcher: takes the oldest note whenever a result shows
  always @(posedge ref_clk) begin
    if (rd_d) begin
      chk("read data", rd_q.pop_front(), reg_rdata);
    end
    if (cycle_done === 1'b1) begin
      chk("done box", done_q.size() ? done_q.pop_front() : 8'hxx, ram_addr.box);
    end
    if (ram_en === 1'b1 && en_d === 1'b0 && slot_q.size() > 0) begin
      chk("slot", slot_q.pop_front(), {ram_addr, ram_read});
    end
    if (watch && ram_en === 1'b1) begin
      run++;
      if (en_d === 1'b1) begin
        chk("held address", last, {ram_addr, ram_read});
      end
    end
    if (watch && ram_en === 1'b0 && en_d === 1'b1) begin
      chk("enable run", 3, run);
    end
    if (ram_en !== 1'b1) begin
      run = 0;
    end
    en_d = ram_en;
    last = {ram_addr, ram_read};
    rd_d = reg_rd;
  end

  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    rst_dut();
    wr(ADDR_SYNC_BOX, 8'h11);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_CYCLE, CYCLE_RESET);
    rd(ADDR_ASYNC_START, ASYNC_START_RESET);
    rd(ADDR_SYNC_BOX, BOX_BASE);
    rd(ADDR_ASYNC_BOX, BOX_BASE);
    rd(ADDR_CYCLE_COUNT, CYCLE_TOP);
    rd(ADDR_STATUS, 8'h01);
    rd(4'hf, 8'h00);
    s = 8'($random(seed));
    wr(ADDR_CYCLE, s);
    rd(ADDR_CYCLE, s);
    end_test("registers");

    // slow steps so each byte sequence runs to its end
    rst_dut();
    wr(ADDR_CTRL, 8'h04);
    priming_enable <= 1'b1;
    watch = 1'b1;
    push_slots(8'h99);
    push_slots(8'h9a);
    i_synth_pulse_model.steps(2, 50);
    watch = 1'b0;
    rd(ADDR_STATUS, 8'h03);
    chk("slots left", 0, 12'(slot_q.size()));
    end_test("byte sequence");

    // every rate select, fast steps, from a fresh divider
    for (int r = 0; r < 4; r++) begin
      rst_dut();
      wr(ADDR_CTRL, 8'(r << 3));
      priming_enable <= 1'b1;
      i_synth_pulse_model.steps(r == 0 ? 15 : 6, 4);
      rd(ADDR_SYNC_BOX, r == 0 ? 8'h99 : (r == 1 ? 8'h9a : 8'h9c));
    end
    i_synth_pulse_model.zero();
    rd(ADDR_SYNC_BOX, BOX_BASE);
    wr(ADDR_CTRL, 8'h04);
    i_synth_pulse_model.steps(1, 4);
    i_synth_pulse_model.zero();
    rd(ADDR_SYNC_BOX, 8'h99);
    priming_enable <= 1'b0;
    i_synth_pulse_model.steps(1, 4);
    rd(ADDR_SYNC_BOX, 8'h99);
    end_test("rates and sync");

    rst_dut();
    wr(ADDR_CYCLE, 8'hfe);
    wr(ADDR_CTRL, 8'h04);
    priming_enable <= 1'b1;
    i_synth_pulse_model.steps(104, 4);
    rd(ADDR_SYNC_BOX, BOX_BASE);
    rd(ADDR_CYCLE_COUNT, CYCLE_TOP);
    done_q.push_back(BOX_BASE);
    i_synth_pulse_model.steps(104, 4);
    rd(ADDR_CYCLE_COUNT, 8'hfe);
    end_test("synchronous cycles");

    // random start point inside the 104 boxes
    rst_dut();
    s = 8'h98 + 8'({$random(seed)} % 104);
    wr(ADDR_ASYNC_START, s);
    wr(ADDR_CYCLE, 8'hff);
    wr(ADDR_CTRL, 8'h07);
    rd(ADDR_ASYNC_BOX, s);
    priming_enable <= 1'b1;
    done_q.push_back(s == 8'h98 ? 8'h98 : 8'h98 - s);
    i_synth_pulse_model.steps(256 - int'(s), 4);
    rd(ADDR_ASYNC_BOX, BOX_BASE);
    end_test("asynchronous cycle");

    repeat (4) @(posedge ref_clk);
    chk("notes left", 0, 12'(rd_q.size() + slot_q.size() + done_q.size()));
    stop_test();
  end
endmodule
